// ---- common/mem_cycle_pkg.sv ----
// constants and types for the configurable memory cycle interface
package mem_cycle_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int NUM_TSTATES = 6;
  localparam logic [31:0] INT_RAM_BASE = 32'h80000000;
  localparam logic [31:0] INT_RAM_LAST = 32'h800007FF;
  localparam int HALF_UNIT_NS = 25;
  localparam int REF_CLK_MHZ = 125;
  localparam int REF_CLK_PERIOD_NS = 8;
  // reference clock cycles per half clock unit, least time rounded up
  localparam int HALF_UNIT_CYCLES = (HALF_UNIT_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam logic [2:0] TSTATE_LEN_MIN = 3'h1;
  localparam logic [2:0] TSTATE_LEN_MAX = 3'h4;
  localparam logic [4:0] STROBE_DLY_MIN = 5'h01;
  localparam logic [4:0] STROBE_DLY_MAX = 5'h1F;
  localparam logic [2:0] TSTATE_LEN_RST = 3'h4;
  localparam logic [4:0] STROBE_DLY_RST = 5'h1F;
  localparam logic LATE_WRITE_RST = 1'b1;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SETUP = 8'h02,
    ST_HOLD  = 8'h04,
    ST_TURN  = 8'h08,
    ST_WAIT  = 8'h10,
    ST_XFER  = 8'h20,
    ST_END   = 8'h40,
    ST_EXTRA = 8'h80
  } cyc_state_t;

  typedef struct packed {
    logic [2:0] t1Len;
    logic [2:0] t2Len;
    logic [2:0] t3Len;
    logic [2:0] t4Len;
    logic [2:0] t5Len;
    logic [2:0] t6Len;
    logic [4:0] strobe1_width_count;
    logic [4:0] strobe2_delay_count;
    logic [4:0] strobe3_delay_count;
    logic [4:0] strobe4_delay_count;
    logic lateWrite;
  } mem_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] byteEn;
    logic write;
    logic refresh;
  } mem_req_t;
endpackage

// ---- hdl/mem_cycle_if.sv ----
// memory cycle engine: six timed states on a multiplexed bus
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - one shared 32-bit address and data bus
// - byte, read, refresh, five strobes, wait, config, request
// - signed byte addresses from 80000000 to 7FFFFFFF
// - internal RAM range never goes external
// - six timing states in fixed order
// - each state lasts one to four units
// - unit is half the exported clock period
// - only fourth state stretches, one unit each
// - low address bits carry write and refresh flags, byte strobes select
// - reads fetch full word, select internally
// - data line 0 low early on writes
// - data line 1 low early on refresh
// - strobe 0 asserted second to fifth state, 2-4 per configured delays
// - strobe 1 releases after count or fifth end
// - waits may move strobe 1 release later
// - write strobes assert third or fourth state
// - write strobes release at sixth state
// - late write data valid at strobe fall
// - wait input high keeps inserting waits
// - after waits fifth state starts rising edge
// - odd unit total adds one extra unit
// - refresh strobe low before first through sixth
module mem_cycle_if
  import mem_cycle_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic clkEn, // freezes all state when low
  input wire mem_cfg_t cfgIn, // configuration, sampled at reset release
  input wire mem_req_t reqIn, // access request
  input wire logic reqValid, // request strobe
  output logic reqReady, // engine idle
  output logic [31:0] rdData, // selected read data
  output logic rdValid, // read data pulse
  output logic intRamHit, // access served by internal RAM
  input wire logic [31:0] adIn, // bus pins in
  output logic [31:0] adOut, // bus pins out
  output logic [31:0] adOe, // bus output enables
  output logic [3:0] byte_write_strobe_n, // byte write strobes
  output logic readStrobeN, // read strobe
  output logic refresh_strobe_n, // refresh strobe
  output logic [4:0] progStrobeN, // programmable strobes 0..4
  output logic exported_cpu_clock, // exported clock
  input wire logic wait_request_in, // wait pin
  input wire logic config_serial_in, // config pin, unused here
  input wire logic busReqIn, // bus request pin
  output logic busGrantOut // bus grant
);
  mem_cfg_t cfgReg;
  logic cfgLoaded;
  cyc_state_t stateReg;
  cyc_state_t stateNext;
  mem_req_t curReg;
  logic [1:0] divCnt;
  logic unitTick;
  logic [2:0] stLenCnt;
  logic [2:0] curLen;
  logic [5:0] t2Units;
  logic [6:0] cycUnits;
  logic waitSeen;
  logic wait1;
  logic wait2;
  logic breq1;
  logic breq2;
  logic [31:0] din1, din2;
  logic stEnd;

  // config captured once after reset release
  // later changes on cfgIn are ignored until the next reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgLoaded <= 1'b0;
      cfgReg <= '0;
    end else if (clkEn && !cfgLoaded) begin
      cfgLoaded <= 1'b1;
      cfgReg <= cfgIn;
    end
  end

  // pin synchronisers
  // two flops per pin, only the second one feeds logic
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait1 <= 1'b0;
      wait2 <= 1'b0;
      breq1 <= 1'b0;
      breq2 <= 1'b0;
      din1 <= 32'h00000000;
      din2 <= 32'h00000000;
    end else if (clkEn) begin
      wait1 <= wait_request_in;
      wait2 <= wait1;
      breq1 <= busReqIn;
      breq2 <= breq1;
      din1 <= adIn;
      din2 <= din1;
    end
  end

  // half clock unit tick and exported clock
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt <= 2'h0;
      exported_cpu_clock <= 1'b0;
    end else if (clkEn) begin
      if (unitTick) begin
        divCnt <= 2'h0;
        exported_cpu_clock <= ~exported_cpu_clock;
      end else begin
        divCnt <= divCnt + 2'h1;
      end
    end
  end
  assign unitTick = (divCnt == 2'(HALF_UNIT_CYCLES - 1));

  // programmed length of the current state
  always_comb begin
    case (stateReg)
      ST_SETUP: curLen = cfgReg.t1Len;
      ST_HOLD: curLen = cfgReg.t2Len;
      ST_TURN: curLen = cfgReg.t3Len;
      ST_WAIT: curLen = cfgReg.t4Len;
      ST_XFER: curLen = cfgReg.t5Len;
      ST_END: curLen = cfgReg.t6Len;
      default: curLen = 3'h1;
    endcase
  end

  // length clamped to one..four units
  logic [2:0] lenEff;
  always_comb begin
    if (curLen < TSTATE_LEN_MIN) begin
      lenEff = TSTATE_LEN_MIN;
    end else if (curLen > TSTATE_LEN_MAX) begin
      lenEff = TSTATE_LEN_MAX;
    end else begin
      lenEff = curLen;
    end
  end

  // state length reached; widened so a saturated count cannot wrap
  logic lenDone;
  assign lenDone = ({1'b0, stLenCnt} + 4'h1) >= {1'b0, lenEff};
  assign stEnd = unitTick && lenDone;

  // request falls in the on-chip RAM range and never goes external
  logic reqInternal;
  assign reqInternal = (reqIn.addr >= INT_RAM_BASE) && (reqIn.addr <= INT_RAM_LAST);

  // cycle may start only on a low-to-high edge of the exported clock
  logic startOk;
  assign startOk = unitTick && !exported_cpu_clock && reqValid && cfgLoaded && !busGrantOut;

  // fourth state: minimum spent and wait pin low; after waits the fifth
  // state must open on a rising edge, so leave while the clock is low
  logic waitExit;
  assign waitExit = unitTick && lenDone && !wait2 && (!waitSeen || !exported_cpu_clock);

  // wait pin still high when the programmed length runs out
  logic waitAgain;
  assign waitAgain = (stateReg == ST_WAIT) && unitTick && lenDone && wait2;

  // edge on which a new cycle is launched
  logic startCyc;
  assign startCyc = (stateReg == ST_IDLE) && (stateNext == ST_SETUP);

  // next state: only the fourth state can be stretched
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      // waiting for an external request
      ST_IDLE: begin
        if (startOk && !reqInternal) begin
          stateNext = ST_SETUP;
        end
      end
      // address setup
      ST_SETUP: begin
        if (stEnd) begin
          stateNext = ST_HOLD;
        end
      end
      // address hold
      ST_HOLD: begin
        if (stEnd) begin
          stateNext = ST_TURN;
        end
      end
      // bus turnaround or write data setup
      ST_TURN: begin
        if (stEnd) begin
          stateNext = ST_WAIT;
        end
      end
      // waits are whole units; after waits leave only on a rising edge
      ST_WAIT: begin
        if (waitExit) begin
          stateNext = ST_XFER;
        end
      end
      // data transfer
      ST_XFER: begin
        if (stEnd) begin
          stateNext = ST_END;
        end
      end
      // end or data hold; odd totals get one more unit
      ST_END: begin
        if (stEnd) begin
          stateNext = cycUnits[0] ? ST_IDLE : ST_EXTRA;
        end
      end
      // filler unit to finish a whole exported clock period
      ST_EXTRA: begin
        if (unitTick) begin
          stateNext = ST_IDLE;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateReg <= ST_IDLE;
      stLenCnt <= 3'h0;
      waitSeen <= 1'b0;
    end else if (clkEn) begin
      stateReg <= stateNext;
      // units spent in the current state, saturating
      if (stateNext != stateReg) begin
        stLenCnt <= 3'h0;
      end else if (unitTick && stLenCnt != 3'h7) begin
        stLenCnt <= stLenCnt + 3'h1;
      end
      // a wait at the length end forces a rising-edge exit later
      if (waitAgain) begin
        waitSeen <= 1'b1;
      end else if (stateNext != stateReg) begin
        waitSeen <= 1'b0;
      end
    end
  end

  // units since start of cycle and since start of the second state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cycUnits <= 7'h00;
      t2Units <= 6'h00;
    end else if (clkEn && unitTick) begin
      if (stateReg == ST_IDLE) begin
        cycUnits <= 7'h00;
      end else begin
        cycUnits <= cycUnits + 7'h01;
      end
      if (stateReg == ST_IDLE || stateReg == ST_SETUP) begin
        t2Units <= 6'h00;
      end else if (t2Units != 6'h3F) begin
        t2Units <= t2Units + 6'h01;
      end
    end
  end

  // request latch and simple bus arbitration
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      curReg <= '0;
      intRamHit <= 1'b0;
      busGrantOut <= 1'b0;
      reqReady <= 1'b0;
    end else if (clkEn) begin
      intRamHit <= 1'b0;
      if (startCyc) begin
        curReg <= reqIn;
      end
      if (stateReg == ST_IDLE && reqValid && reqInternal) begin
        intRamHit <= 1'b1;
      end
      // grant changes only between cycles, never inside one
      if (stateReg == ST_IDLE && stateNext == ST_IDLE) begin
        busGrantOut <= breq2;
      end
      reqReady <= cfgLoaded && stateNext == ST_IDLE && !busGrantOut;
    end
  end

  // a count of zero never fires; delays are whole units from the second state
  function automatic logic dlyHit(input logic [5:0] units, input logic [4:0] cnt);
    dlyHit = ({1'b0, cnt} <= units) && (cnt >= STROBE_DLY_MIN);
  endfunction

  // strobes, bus drive and data capture
  logic inAddr;
  logic inLate;
  logic writeOn;
  logic readCyc;
  logic inCycle;
  logic strobeWin;
  assign inAddr = (stateReg == ST_SETUP) || (stateReg == ST_HOLD);
  assign inLate = (stateReg == ST_TURN) || (stateReg == ST_WAIT) || (stateReg == ST_XFER);
  // early write opens in the third state, late write in the fourth
  assign writeOn = curReg.write && (((stateReg == ST_TURN) && !cfgReg.lateWrite) ||
                   (stateReg == ST_WAIT) || (stateReg == ST_XFER));
  // plain reads only; refresh cycles move no data
  assign readCyc = !curReg.write && !curReg.refresh;
  // any timed state of a running cycle
  assign inCycle = (stateReg != ST_IDLE) && (stateReg != ST_EXTRA);
  // programmable strobes may be low from the second to the fifth state
  assign strobeWin = (stateReg == ST_HOLD) || inLate;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adOut <= 32'h00000000;
      adOe <= 32'h00000000;
      byte_write_strobe_n <= 4'hF;
      readStrobeN <= 1'b1;
      refresh_strobe_n <= 1'b1;
      progStrobeN <= 5'h1F;
    end else if (clkEn) begin
      // address and cycle flags in the first two states
      if (inAddr) begin
        adOut <= {curReg.addr[31:2], ~curReg.refresh, ~curReg.write};
        adOe <= 32'hFFFFFFFF;
      end else if (curReg.write && inCycle) begin
        adOut <= curReg.wdata;
        adOe <= 32'hFFFFFFFF;
      end else begin
        // bus released so the far side can drive it
        adOe <= 32'h00000000;
      end
      byte_write_strobe_n <= writeOn ? ~curReg.byteEn : 4'hF;
      // read strobe spans the third to fifth state
      readStrobeN <= !(readCyc && inLate);
      // low from the start edge until the sixth state has ended
      refresh_strobe_n <= !(curReg.refresh && (inAddr || inLate || stateReg == ST_END)) &&
                          !(reqIn.refresh && startCyc &&
                            reqValid);
      progStrobeN[0] <= !strobeWin;
      progStrobeN[1] <= !(strobeWin &&
                          !dlyHit(t2Units, cfgReg.strobe1_width_count));
      progStrobeN[2] <= !(strobeWin &&
                          dlyHit(t2Units, cfgReg.strobe2_delay_count));
      progStrobeN[3] <= !(strobeWin &&
                          dlyHit(t2Units, cfgReg.strobe3_delay_count));
      progStrobeN[4] <= !(strobeWin &&
                          dlyHit(t2Units, cfgReg.strobe4_delay_count));
    end
  end

  // full word fetched, byte lanes selected inside
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= 32'h00000000;
      rdValid <= 1'b0;
    end else if (clkEn) begin
      rdValid <= 1'b0;
      // data taken on the last edge of the fifth state
      if (stateReg == ST_XFER && stateNext == ST_END && readCyc) begin
        for (int i = 0; i < 4; i++) begin
          rdData[i*8 +: 8] <= curReg.byteEn[i] ? din2[i*8 +: 8] : 8'h00;
        end
        rdValid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/mem_cycle_if_asserts.sv ----
// timing checks on the memory cycle engine pins
`timescale 1ns/1ps
`default_nettype none
module mem_cycle_if_asserts (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic reqReady, // engine idle
  input wire logic intRamHit, // internal access
  input wire logic [3:0] byte_write_strobe_n, // byte write strobes
  input wire logic readStrobeN, // read strobe
  input wire logic refresh_strobe_n, // refresh strobe
  input wire logic [4:0] progStrobeN, // programmable strobes
  input wire logic exported_cpu_clock, // exported clock
  input wire logic busGrantOut, // bus grant
  input wire logic wait_request_in // wait pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_clk_half_unit: assert property ($changed(exported_cpu_clock) |=>
    $stable(exported_cpu_clock) [*3] ##1 $changed(exported_cpu_clock))
    else $error("exported clock half period wrong");
  chk_s0_min_span: assert property ($fell(progStrobeN[0]) |=> !progStrobeN[0] [*8])
    else $error("strobe 0 released too early");
  chk_wr_s0_release: assert property ($rose(&byte_write_strobe_n) |-> $rose(progStrobeN[0]))
    else $error("write strobes not released with strobe 0");
  chk_wr_after_t2: assert property ($fell(&byte_write_strobe_n) |->
    !progStrobeN[0] && $past(!progStrobeN[0], 3))
    else $error("write strobe before third state");
  chk_read_no_wr: assert property (!readStrobeN |-> &byte_write_strobe_n)
    else $error("write strobe during read");
  chk_rfsh_no_wr: assert property (!refresh_strobe_n |-> &byte_write_strobe_n)
    else $error("write strobe during refresh");
  chk_wait_holds: assert property ((!progStrobeN[0] && wait_request_in) [*3]
    |=> !progStrobeN[0])
    else $error("cycle ended while wait high");
  chk_int_quiet: assert property (intRamHit |-> reqReady && progStrobeN == 5'h1F)
    else $error("internal access went external");
  chk_start_bound: assert property ($fell(reqReady) && !busGrantOut |->
    ##[1:24] $fell(progStrobeN[0]))
    else $error("second state late");
  cover property ($fell(&byte_write_strobe_n));
  cover property ($fell(refresh_strobe_n));
  cover property (intRamHit);
  cover property (wait_request_in && !progStrobeN[0]);
endmodule
bind mem_cycle_if mem_cycle_if_asserts i_mem_cycle_if_asserts (.ref_clk, .sys_rst, .reqReady,
  .intRamHit, .byte_write_strobe_n, .readStrobeN, .refresh_strobe_n, .progStrobeN,
  .exported_cpu_clock, .busGrantOut, .wait_request_in);
`default_nettype wire

// ---- tb/mem_cycle_if_tb_top.sv ----
// self-checking bench for the memory cycle engine
`timescale 1ns/1ps
`default_nettype none
module mem_cycle_if_tb_top import mem_cycle_pkg::*; ;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  mem_cfg_t cfgIn = '0;
  mem_req_t reqIn = '0;
  logic reqValid = 1'b0;
  logic [7:0] waitLen = 8'h00;
  logic reqReady, intRamHit, readStrobeN, refresh_strobe_n, exported_cpu_clock, waitReq;
  logic [31:0] rdData, adIn, adOut, adSeen;
  logic [3:0] byte_write_strobe_n;
  logic [4:0] progStrobeN, sPrev;
  logic rfSeen, hitSeen, rdvSeen, rdValid, busGrantOut;
  logic busReq = 1'b0;
  logic oeBad = 1'b0;
  logic [31:0] adOe, oeSeen;
  int sCnt [5];
  int sLen [5];
  int sTab [5] = '{4, 2, 3, 2, 1};
  int bwCnt, bwLen, nMismatch, numChecks;
  mem_cycle_if i_mem_cycle_if (.ref_clk, .sys_rst, .clkEn(1'b1), .cfgIn, .reqIn, .reqValid,
    .reqReady, .rdData, .rdValid, .intRamHit, .adIn, .adOut, .adOe, .byte_write_strobe_n,
    .readStrobeN, .refresh_strobe_n, .progStrobeN, .exported_cpu_clock,
    .wait_request_in(waitReq), .config_serial_in(1'b0), .busReqIn(busReq), .busGrantOut);
  mem_side_model i_mem_side_model (.ref_clk, .adOut, .byteWrN(byte_write_strobe_n),
    .readN(readStrobeN), .s0N(progStrobeN[0]), .waitLen, .adIn, .waitReq);
  initial forever #4 ref_clk = ~ref_clk;
  // strobe low spans in clocks, address seen as strobe 0 falls
  always @(posedge ref_clk) begin
    sPrev <= progStrobeN;
    if (sPrev[0] && !progStrobeN[0]) adSeen <= adOut;
    if (sPrev[0] && !progStrobeN[0]) oeSeen <= adOe;
    if (!readStrobeN && adOe != 32'h00000000) oeBad <= 1'b1;
    if (rdValid) rdvSeen <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (!progStrobeN[k]) sCnt[k] <= sCnt[k] + 1;
      else if (sCnt[k] != 0) begin
        sLen[k] <= sCnt[k];
        sCnt[k] <= 0;
      end
    end
    if (byte_write_strobe_n != 4'hF) bwCnt <= bwCnt + 1;
    else if (bwCnt != 0) begin
      bwLen <= bwCnt;
      bwCnt <= 0;
    end
    if (!refresh_strobe_n) rfSeen <= 1'b1;
    if (intRamHit) hitSeen <= 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic endSim;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
      input logic w, input logic r, input logic [7:0] wt);
    int n;
    rfSeen = 1'b0;
    hitSeen = 1'b0;
    rdvSeen = 1'b0;
    @(posedge ref_clk);
    waitLen <= wt;
    reqIn <= '{a, d, be, w, r};
    reqValid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reqReady && !intRamHit && n < 300);
    if (n >= 300) begin
      nMismatch++;
      $display("BAD request taken exp 1 got 0");
      endSim();
    end
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!reqReady && n < 600);
    if (n >= 600) begin
      nMismatch++;
      $display("BAD cycle end exp 1 got 0");
      endSim();
    end
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    nMismatch++;
    endSim();
  end
  initial begin
    for (int lw = 0; lw < 2; lw++) begin
      sys_rst <= 1'b1;
      cfgIn <= '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h02, 5'h01, 5'h02, 5'h03, lw[0]};
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      acc(32'h00000010, 32'h12345678, 4'hF, 1'b1, 1'b0, 8'h00);
      chk("write flags", 32'h00000012, adSeen);
      chk("byte strobe span", (lw ? 2 : 3) * HALF_UNIT_CYCLES, bwLen);
      acc(32'h00000010, 32'hAAAAAAAA, 4'h2, 1'b1, 1'b0, 8'h00);
      acc(32'h00000010, 32'h0, 4'hF, 1'b0, 1'b0, 8'h00);
      chk("read data", 32'h1234AA78, rdData);
      chk("read flags", 32'h00000013, adSeen);
      chk("read valid", 32'h00000001, {31'h0, rdvSeen});
      chk("address drive", 32'hFFFFFFFF, oeSeen);
      for (int k = 0; k < 5; k++) chk("strobe span", sTab[k] * HALF_UNIT_CYCLES, sLen[k]);
      acc(32'h00000010, 32'h0, 4'hF, 1'b0, 1'b0, 8'h28);
      chk("waited data", 32'h1234AA78, rdData);
      chk("strobe 1 fixed", 2 * HALF_UNIT_CYCLES, sLen[1]);
      chk("wait units", 32'h1, {31'h0, sLen[0] > 4 * HALF_UNIT_CYCLES &&
        sLen[0] % HALF_UNIT_CYCLES == 0});
      acc(32'h0, 32'h0, 4'h0, 1'b0, 1'b1, 8'h00);
      chk("refresh seen", 32'h1, {31'h0, rfSeen});
      chk("refresh flags", 32'h1, {30'h0, adSeen[1:0]});
      acc(32'h80000100, 32'h0, 4'hF, 1'b0, 1'b0, 8'h00);
      chk("internal hit", 32'h1, {31'h0, hitSeen});
      chk("bus released on read", 32'h0, {31'h0, oeBad});
      busReq <= 1'b1;
      repeat (12) @(posedge ref_clk);
      chk("bus grant", 32'h1, {31'h0, busGrantOut});
      busReq <= 1'b0;
      repeat (12) @(posedge ref_clk);
      chk("bus grant off", 32'h0, {31'h0, busGrantOut});
      $display("write mode %0d done", lw);
    end
    endSim();
  end
endmodule
`default_nettype wire

// ---- tb/mem_side_model.sv ----
// word memory on the far side of the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module mem_side_model (
  input wire logic ref_clk, // system clock
  input wire logic [31:0] adOut, // bus from device
  input wire logic [3:0] byteWrN, // byte write strobes
  input wire logic readN, // read strobe
  input wire logic s0N, // strobe 0
  input wire logic [7:0] waitLen, // wait clocks per cycle
  output logic [31:0] adIn, // bus to device
  output logic waitReq // wait request
);
  logic [31:0] mem [16];
  logic [3:0] idx;
  logic [31:0] lastRd = 32'h0;
  logic s0Prev = 1'b1;
  int waitLeft = 0;
  // released bus shows the inverse of the last word
  assign adIn = readN ? ~lastRd : mem[idx];
  assign waitReq = (waitLeft != 0);
  always @(posedge ref_clk) begin
    s0Prev <= s0N;
    if (s0Prev && !s0N) begin
      idx <= adOut[5:2];
      waitLeft <= int'(waitLen);
    end else if (waitLeft != 0) begin
      waitLeft <= waitLeft - 1;
    end
    if (!readN) lastRd <= mem[idx];
    for (int i = 0; i < 4; i++) begin
      if (!byteWrN[i]) mem[idx][8*i +: 8] <= adOut[8*i +: 8];
    end
  end
endmodule
`default_nettype wire
